// ### rtl/wdog_control_flags.sv
// Watchdog control and status registers with timed-access unlock, on AXI4-Lite.
// Assumes synchronous external and power-fail reset pulses; i_nrst is power-on.
//
// Operation
// - Power-up sets the power-on flag, and only a software write changes it.
// - A timeout sets the watchdog interrupt flag, which software or any reset clears.
// - Watchdog reset sets the cause flag, power-fail clears it, else software.
// - Watchdog resets are issued only while the reset enable bit is one.
// - Writing one to restart reloads the counter and the bit clears itself.
// - Without restart a timeout interrupts, and 512 clocks later resets if enabled.
// - External reset loads the control register pattern 0x000xx0, cause kept.
// - Watchdog reset sets cause, power-on/down clear it; power-on sets POR, clears enable.
// - All control bits read back; four protected bits need the timed unlock.
// - Key AAh then 55h on consecutive writes opens a three machine cycle window.
// - The three upper bits of the interrupt enable register read as ones.
// - The priority register holds watchdog and external 2 to 5 priority bits.
// - A control bit doubles serial port one baud rate and is driven out.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "wdog_regs.svh"

module wdog_control_flags #(
    parameter int unsigned PERIOD_CLKS = `WDOG_PERIOD_CLKS
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ext_rst,
    input wire logic i_pfail_rst,
    input wdog_pkg::axil_req_t i_axil,
    output wdog_pkg::axil_rsp_t o_axil,
    output logic o_irq,
    output logic o_wdog_irq,
    output logic o_wdog_reset,
    output logic o_serial1_baud_double,
    output logic [4:0] o_irq_enable_bits,
    output logic [4:0] o_irq_priority_bits
);
    import wdog_pkg::*;

    localparam logic [3:0] TA_LAST = 4'(`TA_WINDOW_CLKS - 1);

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, wdata_q, rd_data;
    logic [11:0] waddr_q;
    logic [3:0] wstrb_q;
    logic rd_hit, wr_fire, wr_hit;
    logic wr_ctrl, wr_en, wr_pri, wr_key, wr_stat, wr_mask;
    logic ta_open;
    ta_state_t ta_q;
    logic [3:0] ta_cnt_q;
    wdog_control_reg_t ctrl;
    logic power_on_q, reset_en_q, irq_flag_q, cause_q, restart_q;
    logic [4:0] en_q, pri_q;
    logic [1:0] stat_q, mask_q;
    logic elapsed, wdog_rst, sys_rst;

    // ------------------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------------------
    // restart reloads counter
    wdog_counter #(.PERIOD_CLKS(PERIOD_CLKS)) u_cnt (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_restart(restart_q | sys_rst),
        .i_reset_en(reset_en_q),
        .o_elapsed(elapsed),
        .o_reset_req(wdog_rst)
    );

    // Any reset other than power-on
    assign sys_rst = i_ext_rst | i_pfail_rst | wdog_rst;

    // ------------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------------
    // Address and data taken in either order, response after both
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (i_axil.awvalid && awready_q) begin
                awready_q <= 1'b0;
                waddr_q <= i_axil.awaddr;
            end
            if (i_axil.wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q <= i_axil.wdata;
                wstrb_q <= i_axil.wstrb;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end else if (bvalid_q && i_axil.bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Write strobes per register, byte lane 0 only
    assign wr_fire = !awready_q && !wready_q && !bvalid_q;
    assign wr_hit = (waddr_q == `WDOG_CTRL_OFFS) || (waddr_q == `EXT_IRQ_EN_OFFS)
        || (waddr_q == `EXT_IRQ_PRI_OFFS) || (waddr_q == `TA_KEY_OFFS)
        || (waddr_q == `IRQ_STAT_OFFS) || (waddr_q == `IRQ_MASK_OFFS);
    assign wr_ctrl = wr_fire && wstrb_q[0] && (waddr_q == `WDOG_CTRL_OFFS);
    assign wr_en = wr_fire && wstrb_q[0] && (waddr_q == `EXT_IRQ_EN_OFFS);
    assign wr_pri = wr_fire && wstrb_q[0] && (waddr_q == `EXT_IRQ_PRI_OFFS);
    assign wr_key = wr_fire && wstrb_q[0] && (waddr_q == `TA_KEY_OFFS);
    assign wr_stat = wr_fire && wstrb_q[0] && (waddr_q == `IRQ_STAT_OFFS);
    assign wr_mask = wr_fire && wstrb_q[0] && (waddr_q == `IRQ_MASK_OFFS);

    // ------------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------------
    // reserved enable bits read high
    always_comb begin
        rd_data = '0;
        rd_hit = 1'b1;
        unique case (i_axil.araddr)
            `WDOG_CTRL_OFFS: rd_data[7:0] = ctrl;
            `EXT_IRQ_EN_OFFS: rd_data[7:0] = {`EN_RSVD_ONES, en_q};
            `EXT_IRQ_PRI_OFFS: rd_data[7:0] = {`PRI_RSVD_ZEROS, pri_q};
            `TA_KEY_OFFS: rd_data[7:0] = 8'h00;
            `IRQ_STAT_OFFS: rd_data[1:0] = stat_q;
            `IRQ_MASK_OFFS: rd_data[1:0] = mask_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // One read in flight, data registered
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `RESP_OKAY;
        end else if (i_axil.arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_data;
            rresp_q <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
        end else if (rvalid_q && i_axil.rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign o_axil = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
        bresp: bresp_q, arready: arready_q, rvalid: rvalid_q, rdata: rdata_q,
        rresp: rresp_q};

    // ------------------------------------------------------------------------
    // Timed-access unlock
    // ------------------------------------------------------------------------
    // key pair opens window
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ta_q <= TA_IDLE;
            ta_cnt_q <= '0;
        end else if (sys_rst) begin
            ta_q <= TA_IDLE;
            ta_cnt_q <= '0;
        end else begin
            unique case (ta_q)
                TA_IDLE: begin
                    if (wr_key && wdata_q[7:0] == `TA_KEY_FIRST) begin
                        ta_q <= TA_GOT_FIRST;
                    end
                end
                TA_GOT_FIRST: begin
                    // Any other write in between breaks the sequence
                    if (wr_key && wdata_q[7:0] == `TA_KEY_SECOND) begin
                        ta_q <= TA_OPEN;
                        ta_cnt_q <= TA_LAST;
                    end else if (wr_fire) begin
                        ta_q <= TA_IDLE;
                    end
                end
                TA_OPEN: begin
                    ta_cnt_q <= ta_cnt_q - 1'b1;
                    if (ta_cnt_q == '0) begin
                        ta_q <= TA_IDLE;
                    end
                end
            endcase
        end
    end

    assign ta_open = (ta_q == TA_OPEN);

    // ------------------------------------------------------------------------
    // Watchdog control register
    // ------------------------------------------------------------------------
    // power-on flag, protected
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            power_on_q <= 1'b1;
        end else if (wr_ctrl && ta_open) begin
            power_on_q <= wdata_q[`CTRL_POR_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            reset_en_q <= 1'b0;
        end else if (wr_ctrl && ta_open) begin
            reset_en_q <= wdata_q[`CTRL_RSTEN_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_flag_q <= 1'b0;
        end else if (sys_rst) begin
            irq_flag_q <= 1'b0;
        end else if (elapsed) begin
            irq_flag_q <= 1'b1;
        end else if (wr_ctrl && ta_open) begin
            irq_flag_q <= wdata_q[`CTRL_IRQF_BIT];
        end
    end

    // cause flag; external reset keeps it
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cause_q <= 1'b0;
        end else if (wdog_rst) begin
            cause_q <= 1'b1;
        end else if (i_pfail_rst) begin
            cause_q <= 1'b0;
        end else if (wr_ctrl && !i_ext_rst) begin
            cause_q <= wdata_q[`CTRL_CAUSE_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            restart_q <= 1'b0;
        end else if (sys_rst || restart_q) begin
            restart_q <= 1'b0;
        end else if (wr_ctrl && ta_open) begin
            restart_q <= wdata_q[`CTRL_RESTART_BIT];
        end
    end

    // baud doubling, plain write; external reset clears
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_serial1_baud_double <= 1'b0;
        end else if (sys_rst) begin
            o_serial1_baud_double <= 1'b0;
        end else if (wr_ctrl) begin
            o_serial1_baud_double <= wdata_q[`CTRL_BAUD_BIT];
        end
    end

    assign ctrl = '{serial1_baud_double: o_serial1_baud_double, power_on: power_on_q,
        unused: 2'h0, wdog_irq_flag: irq_flag_q, wdog_cause_flag: cause_q,
        wdog_reset_enable: reset_en_q, wdog_restart: restart_q};

    // ------------------------------------------------------------------------
    // Extended enable and priority registers
    // ------------------------------------------------------------------------
    // enables, priorities
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            en_q <= '0;
            pri_q <= '0;
        end else if (sys_rst) begin
            en_q <= '0;
            pri_q <= '0;
        end else begin
            if (wr_en) begin
                en_q <= wdata_q[4:0];
            end
            if (wr_pri) begin
                pri_q <= wdata_q[4:0];
            end
        end
    end

    assign o_irq_enable_bits = en_q;
    assign o_irq_priority_bits = pri_q;

    // ------------------------------------------------------------------------
    // Event status, mask and interrupt outputs
    // ------------------------------------------------------------------------
    // Sticky events, write one to clear; a new event wins
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            stat_q[`STAT_ELAPSED_BIT] <= elapsed
                || (stat_q[`STAT_ELAPSED_BIT] && !(wr_stat && wdata_q[`STAT_ELAPSED_BIT]));
            stat_q[`STAT_WRESET_BIT] <= wdog_rst
                || (stat_q[`STAT_WRESET_BIT] && !(wr_stat && wdata_q[`STAT_WRESET_BIT]));
            if (wr_mask) begin
                mask_q <= wdata_q[1:0];
            end
        end
    end

    // interrupt only when enabled; reset pulse gated in counter
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
            o_wdog_irq <= 1'b0;
            o_wdog_reset <= 1'b0;
        end else begin
            o_irq <= |(stat_q & mask_q);
            o_wdog_irq <= irq_flag_q && en_q[`EN_WDOG_BIT];
            o_wdog_reset <= wdog_rst;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_por_hold;
        @(posedge i_clk) disable iff (!i_nrst)
        $fell(power_on_q) |-> $past(wr_ctrl && ta_open);
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("power-on flag fell");

    property p_irqf_set;
        @(posedge i_clk) disable iff (!i_nrst)
        (elapsed && !sys_rst) |=> irq_flag_q;
    endproperty
    a_irqf_set: assert property (p_irqf_set) else $error("irq flag not set");

    property p_cause_pfail;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_pfail_rst && !wdog_rst) |=> !cause_q;
    endproperty
    a_cause_pfail: assert property (p_cause_pfail) else $error("cause kept on pfail");

    property p_rst_gate;
        @(posedge i_clk) disable iff (!i_nrst)
        wdog_rst |-> $past(reset_en_q);
    endproperty
    a_rst_gate: assert property (p_rst_gate) else $error("reset while disabled");

    property p_restart_clr;
        @(posedge i_clk) disable iff (!i_nrst)
        restart_q |=> !restart_q ##1 !elapsed;
    endproperty
    a_restart_clr: assert property (p_restart_clr) else $error("restart stuck");

    property p_rst_delay;
        @(posedge i_clk) disable iff (!i_nrst)
        wdog_rst |-> $past(elapsed, `WDOG_RESET_DELAY_CLKS);
    endproperty
    a_rst_delay: assert property (p_rst_delay) else $error("reset delay wrong");

    property p_ext_pattern;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ext_rst && !wdog_rst && !i_pfail_rst) |=> !o_serial1_baud_double
            && !irq_flag_q && !restart_q && cause_q == $past(cause_q);
    endproperty
    a_ext_pattern: assert property (p_ext_pattern) else $error("ext reset pattern");

    property p_cause_set;
        @(posedge i_clk) disable iff (!i_nrst)
        wdog_rst |=> cause_q ##1 o_wdog_reset == 1'b0;
    endproperty
    a_cause_set: assert property (p_cause_set) else $error("cause not set");

    property p_locked;
        @(posedge i_clk) disable iff (!i_nrst)
        (wr_ctrl && !ta_open) |=> reset_en_q == $past(reset_en_q);
    endproperty
    a_locked: assert property (p_locked) else $error("locked bit written");

    property p_ta_window;
        @(posedge i_clk) disable iff (!i_nrst || sys_rst)
        $rose(ta_open) |-> ta_open[*8] ##1 ta_open[*4] ##1 !ta_open;
    endproperty
    a_ta_window: assert property (p_ta_window) else $error("unlock window length");

    property p_en_rsvd;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_axil.arvalid && arready_q && i_axil.araddr == `EXT_IRQ_EN_OFFS)
            |=> rdata_q[7:5] == `EN_RSVD_ONES;
    endproperty
    a_en_rsvd: assert property (p_en_rsvd) else $error("reserved bits not high");

    property p_pri_wr;
        @(posedge i_clk) disable iff (!i_nrst)
        (wr_pri && !sys_rst) |=> o_irq_priority_bits == $past(wdata_q[4:0]);
    endproperty
    a_pri_wr: assert property (p_pri_wr) else $error("priority not stored");

    property p_baud_wr;
        @(posedge i_clk) disable iff (!i_nrst)
        (wr_ctrl && !sys_rst) |=> o_serial1_baud_double == $past(wdata_q[`CTRL_BAUD_BIT]);
    endproperty
    a_baud_wr: assert property (p_baud_wr) else $error("baud bit not stored");

    c_timeout: cover property (@(posedge i_clk) disable iff (!i_nrst) elapsed);
    c_wreset: cover property (@(posedge i_clk) disable iff (!i_nrst) wdog_rst);
    c_unlock: cover property (@(posedge i_clk) disable iff (!i_nrst) wr_ctrl && ta_open);
endmodule

// ### rtl/wdog_regs.svh
// Register map, field positions, fixed values and timing counts of the watchdog control block.
// Assumes a 40 MHz system clock; included by the design files and the bench.
`ifndef WDOG_REGS_SVH
`define WDOG_REGS_SVH

// ----------------------------------------------------------------------------
// Byte addresses on the register bus
// ----------------------------------------------------------------------------
`define WDOG_CTRL_OFFS 12'h0D8
`define EXT_IRQ_EN_OFFS 12'h0E8
`define EXT_IRQ_PRI_OFFS 12'h0F8
`define TA_KEY_OFFS 12'h100
`define IRQ_STAT_OFFS 12'h104
`define IRQ_MASK_OFFS 12'h108

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_BAUD_BIT 7
`define CTRL_POR_BIT 6
`define CTRL_IRQF_BIT 3
`define CTRL_CAUSE_BIT 2
`define CTRL_RSTEN_BIT 1
`define CTRL_RESTART_BIT 0
`define EN_WDOG_BIT 4
`define STAT_ELAPSED_BIT 0
`define STAT_WRESET_BIT 1

// ----------------------------------------------------------------------------
// Values and counts
// ----------------------------------------------------------------------------
`define TA_KEY_FIRST 8'hAA
`define TA_KEY_SECOND 8'h55
`define EN_RSVD_ONES 3'h7
`define PRI_RSVD_ZEROS 3'h0
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define MACH_CYCLE_CLKS 4
`define TA_WINDOW_MC 3
`define TA_WINDOW_CLKS (`TA_WINDOW_MC * `MACH_CYCLE_CLKS)
`define WDOG_RESET_DELAY_CLKS 512
`define WDOG_PERIOD_CLKS 131072

`endif

// ### rtl/wdog_pkg.sv
// Types shared by the watchdog control block: bus carriers and register layout.
// Assumes a 12-bit AXI4-Lite byte address and 32-bit data.
package wdog_pkg;

    // ------------------------------------------------------------------------
    // AXI4-Lite carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    // ------------------------------------------------------------------------
    // Control register layout and unlock states
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic serial1_baud_double;
        logic power_on;
        logic [1:0] unused;
        logic wdog_irq_flag;
        logic wdog_cause_flag;
        logic wdog_reset_enable;
        logic wdog_restart;
    } wdog_control_reg_t;

    typedef enum logic [1:0] {TA_IDLE, TA_GOT_FIRST, TA_OPEN} ta_state_t;

endpackage

// ### rtl/wdog_counter.sv
// Watchdog period counter and the delayed reset request that follows a timeout.
// Assumes restart is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
`include "wdog_regs.svh"

module wdog_counter #(
    parameter int unsigned PERIOD_CLKS = `WDOG_PERIOD_CLKS
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_restart,
    input wire logic i_reset_en,
    output logic o_elapsed,
    output logic o_reset_req
);
    localparam int CW = $clog2(PERIOD_CLKS);
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CLKS - 1);
    // Arming clock and request clock each count as one of the delay clocks
    localparam logic [9:0] DLY_LAST = 10'(`WDOG_RESET_DELAY_CLKS - 2);

    logic [CW-1:0] cnt_q;
    logic [9:0] dly_q;
    logic armed_q;

    // ------------------------------------------------------------------------
    // Period count
    // ------------------------------------------------------------------------
    // fixed terminal count
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= '0;
            o_elapsed <= 1'b0;
        end else if (i_restart) begin
            cnt_q <= '0;
            o_elapsed <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
            o_elapsed <= (cnt_q == LAST);
        end
    end

    // ------------------------------------------------------------------------
    // Reset delay after timeout
    // ------------------------------------------------------------------------
    // reset 512 later
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            armed_q <= 1'b0;
            dly_q <= '0;
            o_reset_req <= 1'b0;
        end else if (i_restart) begin
            armed_q <= 1'b0;
            dly_q <= '0;
            o_reset_req <= 1'b0;
        end else begin
            o_reset_req <= armed_q && (dly_q == DLY_LAST) && i_reset_en;
            if (o_elapsed && !armed_q) begin
                armed_q <= 1'b1;
                dly_q <= '0;
            end else if (armed_q) begin
                dly_q <= dly_q + 1'b1;
                armed_q <= (dly_q != DLY_LAST);
            end
        end
    end

    property p_period;
        @(posedge i_clk) disable iff (!i_nrst)
        o_elapsed |-> $past(cnt_q) == LAST;
    endproperty
    a_period: assert property (p_period) else $error("elapsed off terminal count");
endmodule

// ### test/wdog_control_flags_tb.sv
// Self-checking bench for the watchdog control block, driven over AXI4-Lite.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`include "wdog_regs.svh"
module wdog_control_flags_tb;
import wdog_pkg::*;
logic clk = 0, nrst = 0, ext = 0, pf = 0, irq, wirq, wrst, baud, lw = 0;
logic [4:0] en, pri;
axil_req_t req = '0;
axil_rsp_t rsp;
logic [31:0] d;
logic [1:0] r;
int error_cnt = 0, checks = 0, cyc = 0, nres = 0, tr = 0, tw = 0, t0;
// ----------------------------------------
// Clock, monitors and hang guard
// ----------------------------------------
always #12.5 clk = ~clk;
always @(posedge clk) begin
    cyc <= cyc + 1;
    lw <= wirq;
    if (wirq === 1'b1 && lw === 1'b0) tr <= cyc;
    if (wrst === 1'b1) nres <= nres + 1;
    if (wrst === 1'b1) tw <= cyc;
    if (cyc == 5000) begin
        error_cnt++;
        wrap_up();
    end
end
wdog_control_flags #(.PERIOD_CLKS(64)) dut (.i_clk(clk), .i_nrst(nrst), .i_ext_rst(ext),
    .i_pfail_rst(pf), .i_axil(req), .o_axil(rsp), .o_irq(irq), .o_wdog_irq(wirq),
    .o_wdog_reset(wrst), .o_serial1_baud_double(baud), .o_irq_enable_bits(en),
    .o_irq_priority_bits(pri));
// ----------------------------------------
// Bus and compare tasks
// ----------------------------------------
task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
        error_cnt++;
        $display("BAD %s exp %h got %h", n, e, g);
    end
endtask
// Handshakes are judged at the negedge so the next posedge sees them settled
task automatic wr(logic [11:0] a, logic [31:0] v);
    logic ha, hw, b;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    b = 0;
    while (!b) begin
        @(negedge clk);
        ha = req.awvalid & rsp.awready;
        hw = req.wvalid & rsp.wready;
        b = rsp.bvalid;
        r = rsp.bresp;
        @(posedge clk);
        if (ha) req.awvalid <= 1'b0;
        if (hw) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
endtask
task automatic rd(logic [11:0] a);
    logic h, b;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    b = 0;
    while (!b) begin
        @(negedge clk);
        h = req.arvalid & rsp.arready;
        b = rsp.rvalid;
        d = rsp.rdata;
        r = rsp.rresp;
        @(posedge clk);
        if (h) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
endtask
task automatic ul;
    wr(`TA_KEY_OFFS, 32'h000000AA);
    wr(`TA_KEY_OFFS, 32'h00000055);
endtask
task automatic pulse(bit p);
    @(posedge clk);
    if (p) pf <= 1'b1; else ext <= 1'b1;
    @(posedge clk);
    pf <= 1'b0;
    ext <= 1'b0;
    repeat (2) @(posedge clk);
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic t_prot;
    rd(`WDOG_CTRL_OFFS);
    chk("ctrl_rst", 32'h40, d);
    rd(`EXT_IRQ_EN_OFFS);
    chk("en_rst", 32'hE0, d);
    rd(12'h0FC);
    chk("unmapped", 2'h3, r);
    wr(`WDOG_CTRL_OFFS, 32'hFF);
    rd(`WDOG_CTRL_OFFS);
    chk("ctrl_locked", 32'hC4, d & 32'hC7);
    chk("baud", 1'b1, baud);
    ul();
    wr(`WDOG_CTRL_OFFS, 32'h00);
    rd(`WDOG_CTRL_OFFS);
    chk("ctrl_open", 32'h00, d & 32'hC7);
    repeat (16) @(posedge clk);
    wr(`WDOG_CTRL_OFFS, 32'h42);
    rd(`WDOG_CTRL_OFFS);
    chk("ctrl_late", 32'h00, d & 32'hC7);
    $display("protection test done");
endtask
task automatic t_irq;
    wr(`IRQ_MASK_OFFS, 32'h1);
    wr(`IRQ_STAT_OFFS, 32'h3);
    t0 = cyc;
    while (irq !== 1'b1 && cyc < t0 + 100) @(posedge clk);
    chk("irq", 1'b1, irq);
    wr(`EXT_IRQ_EN_OFFS, 32'h10);
    wr(`EXT_IRQ_PRI_OFFS, 32'h1F);
    wr(`IRQ_MASK_OFFS, 32'h0);
    repeat (3) @(posedge clk);
    chk("wirq", 1'b1, wirq);
    chk("irq_masked", 1'b0, irq);
    chk("en_bits", 5'h10, en);
    chk("pri_bits", 5'h1F, pri);
    rd(`EXT_IRQ_PRI_OFFS);
    chk("pri_rd", 32'h1F, d);
    ul();
    wr(`WDOG_CTRL_OFFS, 32'h01);
    rd(`WDOG_CTRL_OFFS);
    chk("restart", 32'h0, d & 32'h1);
    $display("interrupt test done");
endtask
task automatic t_wd;
    // Long enough for a full timeout plus reset delay with the enable still clear
    repeat (600) @(posedge clk);
    chk("no_reset", 0, nres);
    ul();
    wr(`WDOG_CTRL_OFFS, 32'h03);
    t0 = cyc;
    while (nres == 0 && cyc < t0 + 800) @(posedge clk);
    // Irq output trails the timeout by two clocks, reset output the request by one
    chk("delay", `WDOG_RESET_DELAY_CLKS - 1, tw - tr);
    rd(`WDOG_CTRL_OFFS);
    chk("ctrl_wd", 32'h06, d & 32'h47);
    wr(`WDOG_CTRL_OFFS, 32'h86);
    pulse(0);
    rd(`WDOG_CTRL_OFFS);
    chk("ctrl_ext", 32'h06, d & 32'hCF);
    rd(`EXT_IRQ_EN_OFFS);
    chk("en_ext", 32'hE0, d);
    pulse(1);
    rd(`WDOG_CTRL_OFFS);
    chk("ctrl_pf", 32'h02, d & 32'h47);
    $display("reset test done");
endtask
task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
        $display("Regression OK");
    end else begin
        $display("Regression broken");
    end
    $finish;
endtask
initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_prot();
    t_irq();
    t_wd();
    wrap_up();
end
endmodule
